//--- hdl/ssipc_pkg.sv
/*
 * Shared constants for the speaker supply, idle and protection control:
 * register map, field positions, reset values, mode codes and timing.
 * Assumes a single 250 MHz clock domain and a 32-bit register word.
 */
package ssipc_pkg;

	// Register map, byte addresses
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_DG    = 8'h04;
	localparam logic [7:0] ADDR_GATE  = 8'h08;
	localparam logic [7:0] ADDR_EMI   = 8'h0c;
	localparam logic [7:0] ADDR_SENSE = 8'h10;
	localparam logic [7:0] ADDR_STAT  = 8'h14;

	// Control register fields
	localparam int CTRL_EN     = 0;
	localparam int CTRL_RETRY  = 1;
	localparam int CTRL_IDLE   = 2;
	localparam int CTRL_SSM    = 3;
	localparam int CTRL_MODE_L = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0008;

	// Dual-rail register fields
	localparam int DG_THR_L  = 0;
	localparam int DG_HOLD_L = 8;
	localparam int DG_DLY_L  = 16;
	localparam logic [31:0] DG_RST = 32'h0000_1010;

	// Gate register fields
	localparam int GT_MUTE_L   = 0;
	localparam int GT_UNMUTE_L = 8;
	localparam int GT_CHSZ_L   = 16;
	localparam logic [31:0] GATE_RST = 32'h0002_0504;

	// Edge rate and spread fields
	localparam int EMI_GEN_L = 0;
	localparam int EMI_LS_L  = 4;
	localparam int EMI_HS_L  = 8;
	localparam int EMI_MOD_L = 12;
	localparam logic [31:0] EMI_RST = 32'h0000_0000;

	// Sense register fields
	localparam int SN_I_EN  = 0;
	localparam int SN_V_EN  = 1;
	localparam int SN_DITH  = 2;
	localparam int SN_I_DC  = 3;
	localparam int SN_V_DC  = 4;
	localparam int SN_TX_EN = 5;
	localparam logic [31:0] SENSE_RST = 32'h0000_0000;

	// Status register fields
	localparam int ST_HIGH = 0;
	localparam int ST_IDLE = 1;
	localparam int ST_WAIT = 2;
	localparam int ST_OFF  = 3;

	// Supply mode codes
	typedef enum logic [1:0] {
		SUP_AUTO = 2'h0,
		SUP_HIGH = 2'h1,
		SUP_LOW  = 2'h2
	} ssipc_supply_t;

	// Channel size codes, audio MSB-aligned in a 32-bit slot
	localparam logic [1:0] CHSZ_16 = 2'h0;
	localparam logic [1:0] CHSZ_24 = 2'h1;
	localparam int LSB_16 = 16;
	localparam int LSB_24 = 8;

	// Idle entry and timing
	localparam int IDLE_SAMPLES = 1024;
	localparam int CLK_MHZ      = 250;
	localparam int RETRY_MS     = 20;
	localparam int RETRY_CYCLES = RETRY_MS * 1000 * CLK_MHZ;
	localparam int DCBLK_SHIFT  = 10;

endpackage

//--- hdl/ssipc_sense_path.sv
/*
 * One sense channel: optional DC block, optional dither, zeroing.
 * Assumes samples arrive on clk with a one-cycle valid strobe.
 */
`timescale 1ns/1ps
module ssipc_sense_path #(
	parameter logic [15:0] SEED = 16'hace1
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Controls
	input  wire logic        en,
	input  wire logic        dc_en,
	input  wire logic        dith_en,
	input  wire logic        zero,
	// Samples
	input  wire logic        din_valid,
	input  wire logic [15:0] din,
	output      logic [15:0] dout
);
	import ssipc_pkg::*;

	logic signed [19:0] x1_r;
	logic signed [19:0] y1_r;
	logic signed [19:0] y_nxt;
	logic signed [19:0] sum;
	logic        [15:0] lfsr_r;
	logic        [15:0] dout_r;

	// First-order highpass, leak set by the shift
	always_comb begin
		y_nxt = 20'(signed'(din)) - x1_r + y1_r - (y1_r >>> DCBLK_SHIFT);
		sum = (dc_en ? y_nxt : 20'(signed'(din)))
			+ 20'(dith_en ? lfsr_r[0] : 1'b0);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			x1_r <= '0;
			y1_r <= '0;
		end else if (din_valid) begin
			x1_r <= 20'(signed'(din));
			y1_r <= dc_en ? y_nxt : 20'h0_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			lfsr_r <= SEED;
		else if (din_valid)
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13]
				^ lfsr_r[12] ^ lfsr_r[10]};
	end

	// Saturate rather than wrap after filter and dither
	always_ff @(posedge clk) begin
		if (sys_rst)
			dout_r <= 16'h0000;
		else if (!en || zero)
			dout_r <= 16'h0000;
		else if (din_valid) begin
			if (sum > 20'sh07fff)
				dout_r <= 16'h7fff;
			else if (sum < -20'sh08000)
				dout_r <= 16'h8000;
			else
				dout_r <= sum[15:0];
		end
	end

	assign dout = dout_r;

endmodule // ssipc_sense_path

//--- hdl/ssipc_top.sv
/*
 * Speaker supply rail selection, signal delay, idle mode, overcurrent
 * handling and sense data path, with a plain register port.
 * Assumes audio and sense samples arrive already parallel on clk.
 */
// Function
// - Auto mode: level above threshold selects high rail, indicator low.
// - Auto mode: back to battery rail only at zero cross after hold.
// - Auto mode: audio path delayed by a programmable sample count.
// - Supply mode 0x0 is automatic dual-rail and the reset default.
// - Mode 0x1 fixes high rail, mode 0x2 fixes battery rail.
// - Mode 0x2: battery rail always, indicator held high.
// - Mode 0x1: high rail always, indicator held low.
// - Idle entered after more than 1024 samples below mute level.
// - While idle both sense outputs are zero.
// - One sample above unmute level leaves idle at once.
// - Levels are active-bit counts from LSB set by channel size.
// - Spread switching on after reset; index field sets its width.
// - Edge rate set by general, low-side and high-side fields.
// - Auto-retry: overcurrent flags, disables, re-enables after 20 ms.
// - No retry: overcurrent flags, disables, clears global enable.
// - Two 16-bit sense channels, current and voltage, own enables.
// - Sense samples go out on PCM only when transmit enabled.
// - Dither bit adds one LSB peak-to-peak dither to both.
// - Each sense path has its own DC block enable.
`timescale 1ns/1ps
module ssipc_top #(
	parameter int DLY_DEPTH    = 16,
	parameter int RETRY_CYCLES = ssipc_pkg::RETRY_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output      logic [31:0] reg_rdata,
	// Audio in and delayed audio out
	input  wire logic [31:0] spk_sample,
	input  wire logic        spk_valid,
	output      logic [31:0] amp_sample,
	output      logic        amp_valid,
	// Rail control
	output      logic        rail_high_sel,
	output      logic        low_rail_indicator,
	// Overcurrent
	input  wire logic        ovc_pin,
	output      logic        amp_out_enable,
	output      logic        ovc_event,
	// Sense converters and PCM transmit
	input  wire logic [15:0] adc_i_data,
	input  wire logic [15:0] adc_v_data,
	input  wire logic        adc_valid,
	output      logic        sense_current_enable,
	output      logic        sense_voltage_enable,
	output      logic [15:0] pcm_tx_i,
	output      logic [15:0] pcm_tx_v,
	output      logic        pcm_tx_valid,
	// Switching control
	output      logic        spread_switching,
	output      logic [2:0]  spread_modulation_index,
	output      logic [2:0]  edge_rate_general,
	output      logic [2:0]  edge_rate_low_side,
	output      logic [2:0]  edge_rate_high_side
);
	import ssipc_pkg::*;

	localparam int DW = $clog2(DLY_DEPTH);

	if (DLY_DEPTH < 2 || DLY_DEPTH > 256 || RETRY_CYCLES < 1
		|| (DLY_DEPTH & (DLY_DEPTH - 1)) != 0) begin : g_param_chk
		$error("ssipc_top: unsupported parameter value");
	end

	typedef enum {RAIL_LOW, RAIL_HIGH} ssipc_rail_t;
	typedef enum {OC_RUN, OC_WAIT} ssipc_oc_t;

	logic [31:0]   ctrl_r;
	logic [31:0]   dg_r;
	logic [31:0]   gate_r;
	logic [31:0]   emi_r;
	logic [31:0]   sense_r;
	logic [31:0]   rdata_r;
	ssipc_supply_t mode;
	ssipc_rail_t   rail_r;
	ssipc_oc_t     oc_r;
	logic          idle_r;
	logic [10:0]   quiet_cnt_r;
	logic [7:0]    hold_cnt_r;
	logic [31:0]   retry_cnt_r;
	logic          ovc_s1_r;
	logic          ovc_s2_r;
	logic          ovc_trip;
	logic [5:0]    level;
	logic          zero_cross;
	logic [31:0]   prev_r;
	logic [31:0]   dly_mem [DLY_DEPTH];
	logic [DW-1:0] wptr_r;
	logic [DW-1:0] dly;
	logic [31:0]   amp_r;
	logic          amp_vld_r;
	logic          high_r;
	logic          lri_r;
	logic          ampen_r;
	logic          ovce_r;
	logic [15:0]   tx_i_r;
	logic [15:0]   tx_v_r;
	logic          tx_vld_r;
	logic [15:0]   sn_i;
	logic [15:0]   sn_v;
	logic          sn_vld_r;

	// Active bits above the channel LSB
	function automatic logic [5:0] active_bits(
		input logic [31:0] s,
		input logic [1:0]  chsz
	);
		logic [31:0] mag;
		logic [5:0]  n;
		mag = s[31] ? ~s : s;
		if (chsz == CHSZ_16)
			mag = mag >> LSB_16;
		else if (chsz == CHSZ_24)
			mag = mag >> LSB_24;
		n = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (mag[i])
				n = 6'(i + 1);
		end
		return n;
	endfunction

	assign mode = ssipc_supply_t'(ctrl_r[CTRL_MODE_L +: 2]);
	assign level = active_bits(spk_sample, gate_r[GT_CHSZ_L +: 2]);
	assign zero_cross = spk_sample == 32'h0 || spk_sample[31] != prev_r[31];

	// Register writes; hardware clear of enable wins over software
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// Auto mode and spread switching by default
			ctrl_r  <= CTRL_RST;
			dg_r    <= DG_RST;
			gate_r  <= GATE_RST;
			emi_r   <= EMI_RST;
			sense_r <= SENSE_RST;
		end else begin
			if (reg_wr) begin
				unique case (reg_addr)
					ADDR_CTRL:  ctrl_r  <= reg_wdata;
					ADDR_DG:    dg_r    <= reg_wdata;
					ADDR_GATE:  gate_r  <= reg_wdata;
					ADDR_EMI:   emi_r   <= reg_wdata;
					ADDR_SENSE: sense_r <= reg_wdata;
					default: ;
				endcase
			end
			// Trip without retry drops global enable
			if (ovc_trip && !ctrl_r[CTRL_RETRY])
				ctrl_r[CTRL_EN] <= 1'b0;
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk) begin
		if (sys_rst)
			rdata_r <= 32'h0;
		else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CTRL:  rdata_r <= ctrl_r;
				ADDR_DG:    rdata_r <= dg_r;
				ADDR_GATE:  rdata_r <= gate_r;
				ADDR_EMI:   rdata_r <= emi_r;
				ADDR_SENSE: rdata_r <= sense_r;
				ADDR_STAT:  rdata_r <= {28'h0, oc_r == OC_RUN
					&& !ctrl_r[CTRL_EN], oc_r == OC_WAIT, idle_r,
					rail_r == RAIL_HIGH};
				default:    rdata_r <= 32'h0;
			endcase
		end else
			rdata_r <= 32'h0;
	end

	// Pin is asynchronous to clk
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ovc_s1_r <= 1'b0;
			ovc_s2_r <= 1'b0;
		end else begin
			ovc_s1_r <= ovc_pin;
			ovc_s2_r <= ovc_s1_r;
		end
	end

	assign ovc_trip = ovc_s2_r && oc_r == OC_RUN && ctrl_r[CTRL_EN];

	// Timed retry repeats while the fault stays
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			oc_r        <= OC_RUN;
			retry_cnt_r <= 32'h0;
			ovce_r      <= 1'b0;
		end else begin
			ovce_r <= ovc_trip;
			unique case (oc_r)
				OC_RUN: begin
					if (ovc_trip && ctrl_r[CTRL_RETRY]) begin
						oc_r        <= OC_WAIT;
						retry_cnt_r <= 32'(RETRY_CYCLES - 1);
					end
				end
				OC_WAIT: begin
					if (retry_cnt_r == 32'h0)
						oc_r <= OC_RUN;
					else
						retry_cnt_r <= retry_cnt_r - 32'h1;
				end
			endcase
		end
	end

	// Output off while tripped or disabled
	always_ff @(posedge clk) begin
		if (sys_rst)
			ampen_r <= 1'b0;
		else
			ampen_r <= ctrl_r[CTRL_EN] && oc_r == OC_RUN && !ovc_trip;
	end

	// Rail selection, one decision per input sample in auto mode; fixed modes force the rail every cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rail_r     <= RAIL_LOW;
			hold_cnt_r <= 8'h00;
			prev_r     <= 32'h0;
		end else if (mode == SUP_HIGH) begin
			rail_r <= RAIL_HIGH;
		end else if (mode != SUP_AUTO) begin
			rail_r <= RAIL_LOW;
		end else if (spk_valid) begin
			prev_r <= spk_sample;
			// Rise above threshold goes high at once
			if (level > dg_r[DG_THR_L +: 6]) begin
				rail_r     <= RAIL_HIGH;
				hold_cnt_r <= 8'h00;
			end else if (rail_r == RAIL_HIGH) begin
				// Hold then wait for zero cross
				if (hold_cnt_r >= dg_r[DG_HOLD_L +: 8]) begin
					if (zero_cross)
						rail_r <= RAIL_LOW;
				end else
					hold_cnt_r <= hold_cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			high_r <= 1'b0;
			lri_r  <= 1'b1;
		end else begin
			high_r <= rail_r == RAIL_HIGH;
			lri_r  <= rail_r == RAIL_LOW;
		end
	end

	// Delay only in auto mode; fixed modes see only the one-cycle output register
	assign dly = mode == SUP_AUTO ? dg_r[DG_DLY_L +: DW] : '0;

	always_ff @(posedge clk) begin
		if (spk_valid)
			dly_mem[wptr_r] <= spk_sample;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wptr_r    <= '0;
			amp_r     <= 32'h0;
			amp_vld_r <= 1'b0;
		end else begin
			amp_vld_r <= spk_valid;
			if (spk_valid) begin
				wptr_r <= wptr_r + 1'b1;
				amp_r  <= dly == '0 ? spk_sample
					: dly_mem[DW'(wptr_r - dly)];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idle_r      <= 1'b0;
			quiet_cnt_r <= 11'h000;
		end else if (!ctrl_r[CTRL_IDLE]) begin
			idle_r      <= 1'b0;
			quiet_cnt_r <= 11'h000;
		end else if (spk_valid) begin
			if (level >= gate_r[GT_MUTE_L +: 6])
				quiet_cnt_r <= 11'h000;
			else if (quiet_cnt_r <= 11'(IDLE_SAMPLES))
				quiet_cnt_r <= quiet_cnt_r + 11'h001;
			if (level > gate_r[GT_UNMUTE_L +: 6])
				idle_r <= 1'b0;
			else if (level < gate_r[GT_MUTE_L +: 6]
				&& quiet_cnt_r >= 11'(IDLE_SAMPLES))
				idle_r <= 1'b1;
		end
	end

	ssipc_sense_path #(
		.SEED(16'hace1)
	) u_sense_i (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.en       (sense_r[SN_I_EN]),
		.dc_en    (sense_r[SN_I_DC]),
		.dith_en  (sense_r[SN_DITH]),
		.zero     (idle_r),
		.din_valid(adc_valid),
		.din      (adc_i_data),
		.dout     (sn_i)
	);

	ssipc_sense_path #(
		.SEED(16'h5a3c)
	) u_sense_v (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.en       (sense_r[SN_V_EN]),
		.dc_en    (sense_r[SN_V_DC]),
		.dith_en  (sense_r[SN_DITH]),
		.zero     (idle_r),
		.din_valid(adc_valid),
		.din      (adc_v_data),
		.dout     (sn_v)
	);

	// PCM transmit gated by its enable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sn_vld_r <= 1'b0;
			tx_i_r   <= 16'h0000;
			tx_v_r   <= 16'h0000;
			tx_vld_r <= 1'b0;
		end else begin
			sn_vld_r <= adc_valid;
			tx_vld_r <= sn_vld_r && sense_r[SN_TX_EN];
			tx_i_r   <= sense_r[SN_TX_EN] ? sn_i : 16'h0000;
			tx_v_r   <= sense_r[SN_TX_EN] ? sn_v : 16'h0000;
		end
	end

	assign reg_rdata            = rdata_r;
	assign amp_sample           = amp_r;
	assign amp_valid            = amp_vld_r;
	assign rail_high_sel        = high_r;
	assign low_rail_indicator   = lri_r;
	assign amp_out_enable       = ampen_r;
	assign ovc_event            = ovce_r;
	// Converter enables from their own bits
	assign sense_current_enable = sense_r[SN_I_EN];
	assign sense_voltage_enable = sense_r[SN_V_EN];
	assign pcm_tx_i             = tx_i_r;
	assign pcm_tx_v             = tx_v_r;
	assign pcm_tx_valid         = tx_vld_r;
	assign spread_switching        = ctrl_r[CTRL_SSM];
	assign spread_modulation_index = emi_r[EMI_MOD_L +: 3];
	assign edge_rate_general       = emi_r[EMI_GEN_L +: 3];
	assign edge_rate_low_side      = emi_r[EMI_LS_L +: 3];
	assign edge_rate_high_side     = emi_r[EMI_HS_L +: 3];

endmodule // ssipc_top

//--- verification/ssipc_asserts.sv
/* Checker on the ports of ssipc_top.
   Assumes one clock domain and the synchronous reset sys_rst. */
`timescale 1ns/1ps
module ssipc_asserts
	import ssipc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Audio and rails
	input wire logic        spk_valid,
	input wire logic        amp_valid,
	input wire logic        rail_high_sel,
	input wire logic        low_rail_indicator,
	// Overcurrent
	input wire logic        ovc_pin,
	input wire logic        amp_out_enable,
	input wire logic        ovc_event,
	// Sense and switching
	input wire logic        adc_valid,
	input wire logic        pcm_tx_valid,
	input wire logic        sense_current_enable,
	input wire logic        spread_switching,
	input wire logic [2:0]  edge_rate_general
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	hole_read_a: assert property (reg_rd && reg_addr > ADDR_STAT |=> !reg_rdata)
		else $error("unmapped read returned data");
	rail_excl_a: assert property (low_rail_indicator != rail_high_sel)
		else $error("indicator disagrees with rail");
	audio_lat_a: assert property (spk_valid |=> amp_valid)
		else $error("delayed audio strobe missing");
	tx_lat_a: assert property (pcm_tx_valid |-> $past(adc_valid, 2))
		else $error("sense output without sample");
	trip_resp_a: assert property ($rose(ovc_pin) && amp_out_enable
		|-> ##[2:4] ovc_event) else $error("overcurrent not flagged");
	trip_off_a: assert property (ovc_event |-> !amp_out_enable)
		else $error("output on during trip");
	trip_pulse_a: assert property (ovc_event |=> !ovc_event)
		else $error("trip flag longer than a pulse");
	cfg_hold_a: assert property (!reg_wr |=>
		$stable({sense_current_enable, edge_rate_general}))
		else $error("field changed without write");
	spread_rst_a: assert property ($fell(sys_rst) |-> spread_switching)
		else $error("spread off after reset");

	cover property (ovc_event);
	cover property (pcm_tx_valid);
	cover property ($rose(rail_high_sel));
endmodule // ssipc_asserts

bind ssipc_top ssipc_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .spk_valid(spk_valid), .amp_valid(amp_valid),
	.rail_high_sel(rail_high_sel), .low_rail_indicator(low_rail_indicator),
	.ovc_pin(ovc_pin), .amp_out_enable(amp_out_enable),
	.ovc_event(ovc_event), .adc_valid(adc_valid),
	.pcm_tx_valid(pcm_tx_valid), .sense_current_enable(sense_current_enable),
	.spread_switching(spread_switching),
	.edge_rate_general(edge_rate_general));

//--- verification/ssipc_host.sv
/* Host model: register master and audio sample source.
   Assumes its tasks are called from one bench process. */
`timescale 1ns/1ps
module ssipc_host (
	// Clock
	input  wire logic        clk,
	// Register port
	output      logic [7:0]  reg_addr,
	output      logic [31:0] reg_wdata,
	output      logic        reg_wr,
	output      logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	// Audio
	output      logic [31:0] spk_sample,
	output      logic        spk_valid
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		spk_sample = 32'h0;
		spk_valid = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask

	// Idle slot shows inverted data, not a stale copy
	task automatic send(input logic [31:0] s);
		@(posedge clk);
		spk_sample <= s;
		spk_valid <= 1'b1;
		@(posedge clk);
		spk_valid <= 1'b0;
		spk_sample <= ~s;
	endtask
endmodule // ssipc_host

//--- verification/ssipc_top_tb.sv
/* Self-checking bench for ssipc_top with the host model.
   Assumes a 250 MHz clock and a short retry count. */
`timescale 1ns/1ps
module ssipc_top_tb;
	import ssipc_pkg::*;
	localparam int RETRY = 50;
	localparam logic [7:0] RA [6] = '{ADDR_CTRL, ADDR_DG, ADDR_GATE,
		ADDR_EMI, ADDR_SENSE, 8'h18};
	localparam logic [31:0] RV [6] = '{CTRL_RST, DG_RST, GATE_RST,
		EMI_RST, SENSE_RST, 32'h0};
	logic        clk, sys_rst, reg_wr, reg_rd, spk_valid, amp_valid;
	logic        rail_high_sel, low_rail_indicator, ovc_pin, ovc_event;
	logic        amp_out_enable, adc_valid, pcm_tx_valid, hit;
	logic        sense_current_enable, sense_voltage_enable;
	logic        spread_switching;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, spk_sample, amp_sample, d;
	logic [15:0] adc_i_data, adc_v_data, pcm_tx_i, pcm_tx_v;
	logic [2:0]  spread_modulation_index, edge_rate_general;
	logic [2:0]  edge_rate_low_side, edge_rate_high_side;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          n;

	ssipc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.spk_sample(spk_sample), .spk_valid(spk_valid));

	ssipc_top #(.DLY_DEPTH(16), .RETRY_CYCLES(RETRY)) DUT (.clk(clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.spk_sample(spk_sample), .spk_valid(spk_valid),
		.amp_sample(amp_sample), .amp_valid(amp_valid),
		.rail_high_sel(rail_high_sel),
		.low_rail_indicator(low_rail_indicator), .ovc_pin(ovc_pin),
		.amp_out_enable(amp_out_enable), .ovc_event(ovc_event),
		.adc_i_data(adc_i_data), .adc_v_data(adc_v_data),
		.adc_valid(adc_valid), .sense_current_enable(sense_current_enable),
		.sense_voltage_enable(sense_voltage_enable), .pcm_tx_i(pcm_tx_i),
		.pcm_tx_v(pcm_tx_v), .pcm_tx_valid(pcm_tx_valid),
		.spread_switching(spread_switching),
		.spread_modulation_index(spread_modulation_index),
		.edge_rate_general(edge_rate_general),
		.edge_rate_low_side(edge_rate_low_side),
		.edge_rate_high_side(edge_rate_high_side));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t %s", $time, m);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic adc(input logic [15:0] i, input logic [15:0] v);
		@(posedge clk);
		adc_i_data <= i;
		adc_v_data <= v;
		adc_valid <= 1'b1;
		@(posedge clk);
		adc_valid <= 1'b0;
		adc_i_data <= ~i;
		adc_v_data <= ~v;
		tick(2);
	endtask

	task automatic rail(input logic h, input string m);
		tick(3);
		chk(rail_high_sel, h, m);
		chk(low_rail_indicator, !h, m);
	endtask

	task automatic stat(input logic v, input string m);
		host.rd(ADDR_STAT, d);
		chk(d[ST_IDLE], v, m);
	endtask

	task automatic trip();
		@(posedge clk);
		ovc_pin <= 1'b1;
		tick(3);
		ovc_pin <= 1'b0;
		n = 0;
		while (ovc_event !== 1'b1 && n < 8) begin
			@(posedge clk);
			n++;
		end
		chk(ovc_event, 1'b1, "trip not flagged");
	endtask

	task automatic t_regs();
		chk(spread_switching, 1'b1, "spread off at reset");
		host.wr(8'h18, 32'hffff_ffff);
		for (int k = 0; k < 6; k++) begin
			host.rd(RA[k], d);
			chk(d, RV[k], "register reset value");
		end
		host.wr(ADDR_EMI, 32'h0000_5321);
		tick(2);
		chk(edge_rate_general, 3'h1, "general edge");
		chk(edge_rate_low_side, 3'h2, "low side edge");
		chk(edge_rate_high_side, 3'h3, "high side edge");
		chk(spread_modulation_index, 3'h5, "spread index");
		host.wr(ADDR_CTRL, 32'h0);
		tick(2);
		chk(spread_switching, 1'b0, "spread not off");
	endtask

	task automatic t_modes();
		host.wr(ADDR_CTRL, 32'h0000_0018);
		host.send(32'h1);
		rail(1'b1, "fixed high rail");
		host.wr(ADDR_CTRL, 32'h0000_0028);
		host.send(32'h0100_0000);
		rail(1'b0, "fixed battery rail");
		host.wr(ADDR_CTRL, CTRL_RST);
		host.send(32'h0001_0000);
		rail(1'b1, "auto rail rise");
		host.send(32'h0);
		rail(1'b1, "left before hold");
		repeat (20) host.send(32'h1);
		rail(1'b1, "left without zero cross");
		host.send(32'h0);
		rail(1'b0, "no return to battery");
	endtask

	task automatic t_delay();
		host.wr(ADDR_DG, 32'h0003_1010);
		for (int k = 0; k < 5; k++) begin
			host.send(32'h11 + k);
			@(posedge clk);
		end
		chk(amp_sample, 32'h12, "signal delay");
		chk(amp_valid, 1'b1, "delayed strobe missing");
		host.wr(ADDR_DG, DG_RST);
	endtask

	task automatic t_sense();
		host.wr(ADDR_SENSE, 32'h0000_0003);
		adc(16'h1234, 16'h5678);
		chk(pcm_tx_valid, 1'b0, "transmit not gated");
		host.wr(ADDR_SENSE, 32'h0000_0021);
		adc(16'h1234, 16'h5678);
		chk(pcm_tx_valid, 1'b1, "no transmit");
		chk(pcm_tx_i, 32'h1234, "current data");
		chk(pcm_tx_v, 32'h0, "voltage not off");
		chk(sense_current_enable, 1'b1, "current enable off");
		chk(sense_voltage_enable, 1'b0, "voltage enable on");
		host.wr(ADDR_SENSE, 32'h0000_0027);
		hit = 1'b0;
		repeat (8) begin
			adc(16'h1234, 16'h5678);
			chk(pcm_tx_v - 16'h5678 <= 16'h1, 1'b1, "dither range");
			hit = hit | (pcm_tx_i == 16'h1235);
		end
		chk(hit, 1'b1, "no dither");
		host.wr(ADDR_SENSE, 32'h0000_002b);
		repeat (2000) adc(16'h4000, 16'h4000);
		chk(pcm_tx_i < 16'h2000, 1'b1, "dc not blocked");
		chk(pcm_tx_v, 32'h4000, "voltage filtered");
	endtask

	task automatic t_idle();
		// Both enables together, levels ordered, auto rail
		host.wr(ADDR_SENSE, 32'h0000_0023);
		host.wr(ADDR_CTRL, 32'h0000_000d);
		repeat (1024) host.send(32'h7);
		host.send(32'h8);
		repeat (1024) host.send(32'h7);
		stat(1'b0, "count not restarted");
		host.send(32'h7);
		stat(1'b1, "idle not entered");
		adc(16'h1234, 16'h5678);
		chk(pcm_tx_i, 32'h0, "idle current data");
		chk(pcm_tx_v, 32'h0, "idle voltage data");
		host.send(32'h10);
		stat(1'b1, "left at unmute level");
		host.wr(ADDR_GATE, 32'h0000_0504);
		host.send(32'h20);
		stat(1'b1, "bits below lsb counted");
		host.wr(ADDR_GATE, 32'h0001_0504);
		host.send(32'h0000_0400);
		stat(1'b1, "24-bit lsb misplaced");
		host.send(32'h0020_0000);
		stat(1'b0, "idle not left");
		adc(16'h1234, 16'h5678);
		chk(pcm_tx_v, 32'h5678, "sense not resumed");
		host.wr(ADDR_GATE, GATE_RST);
	endtask

	task automatic t_ovc();
		host.wr(ADDR_CTRL, 32'h0000_000b);
		tick(2);
		chk(amp_out_enable, 1'b1, "output not on");
		trip();
		n = 0;
		while (amp_out_enable !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(n >= RETRY - 2 && n <= RETRY + 4, 1'b1, "retry delay");
		// Fault held across two retry periods
		@(posedge clk);
		ovc_pin <= 1'b1;
		n = 0;
		repeat (2 * RETRY + 20) begin
			@(posedge clk);
			n += ovc_event;
		end
		ovc_pin <= 1'b0;
		chk(n >= 2, 1'b1, "no repeated retry");
		tick(RETRY + 10);
		host.wr(ADDR_CTRL, 32'h0000_0009);
		trip();
		tick(2);
		chk(amp_out_enable, 1'b0, "output still on");
		host.rd(ADDR_CTRL, d);
		chk(d, 32'h0000_0008, "enable not cleared");
		host.wr(ADDR_CTRL, 32'h0000_0009);
		tick(2);
		chk(amp_out_enable, 1'b1, "re-enable failed");
	endtask

	task automatic final_report();
		if (err_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Ceiling well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			final_report();
		end
	end

	initial begin
		sys_rst = 1'b1;
		ovc_pin = 1'b0;
		adc_valid = 1'b0;
		adc_i_data = 16'h0;
		adc_v_data = 16'h0;
		tick(5);
		sys_rst <= 1'b0;
		t_regs();
		t_modes();
		t_delay();
		t_sense();
		t_idle();
		t_ovc();
		final_report();
	end
endmodule // ssipc_top_tb
